/* design/crxef_pkg.sv */
// Constants and types for the CAN receive error and filter block
package crxef_pkg;
    localparam logic [11:0] OFS_GCFG = 12'h000;
    localparam logic [11:0] OFS_CTRL = 12'h004;
    localparam logic [11:0] OFS_ERFL = 12'h008;
    localparam logic [11:0] OFS_STS = 12'h00C;
    localparam logic [11:0] OFS_GERFL = 12'h010;
    localparam logic [3:0] RULE_PAGE = 4'h1;
    localparam logic [1:0] SUB_ID = 2'h0;
    localparam logic [1:0] SUB_MASK = 2'h1;
    localparam logic [1:0] SUB_PTR = 2'h2;
    localparam int GCFG_DCE = 0;
    localparam int GCFG_DRE = 1;
    localparam int GCFG_MIRR = 2;
    localparam int GCFG_MLIE = 3;
    localparam int GCFG_RNUM_LSB = 8;
    localparam logic [31:0] GCFG_RST = 32'h0000_0000;
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_FBOE = 2;
    localparam int CTL_POL_LSB = 3;
    localparam int CTL_BEIE = 5;
    localparam int CTL_BORIE = 6;
    localparam logic [31:0] CTL_RST = 32'h0000_0001;
    localparam int EF_BUS = 0;
    localparam int EF_ADLM = 1;
    localparam int EF_REC = 2;
    localparam int EF_DOM = 3;
    localparam int EF_CRC = 4;
    localparam int EF_ACK = 5;
    localparam int EF_FORM = 6;
    localparam int EF_STUFF = 7;
    localparam int EF_BUSOFF_RECOVERY_FLAG = 8;
    localparam int GE_DLC = 0;
    localparam int GE_TRF_LOST = 1;
    localparam int GE_RXF_LSB = 8;
    localparam int ID_OWN = 29;
    localparam int ID_RTR = 30;
    localparam int ID_IDE = 31;
    localparam int PTR_DLC_LSB = 0;
    localparam int PTR_LBL_LSB = 4;
    localparam int PTR_RXF_LSB = 16;
    localparam int PTR_TRF = 24;
    localparam int PTR_BUF = 25;
    localparam int PTR_BNUM_LSB = 26;
    localparam logic [1:0] MODE_COMM = 2'h0;
    localparam logic [1:0] MODE_RESET = 2'h1;
    localparam logic [1:0] MODE_STBY = 2'h2;
    localparam logic [1:0] POL_STBY_START = 2'h1;
    localparam logic [1:0] POL_STBY_REQ = 2'h3;
    localparam logic [7:0] BO_SEQ_CNT = 8'h80;
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_COMM = 2'b01,
        ST_STBY = 2'b10,
        ST_BUSOFF = 2'b11
    } crxef_state_t;
endpackage

/* design/crxef_top.sv */
// Channel error flags, bus-off recovery and receive rule filtering
//
// What this block does
// - Sending recessive but seeing dominant sets the dominant bit error flag.
// - A checksum mismatch in a received frame sets the crc error flag.
// - A transmitted frame without acknowledge sets the ack error flag.
// - An illegal level in a fixed-format field sets the form error flag.
// - A bit stuffing violation on the bus sets the stuff error flag.
// - Recovery flag set only after 128 sequences of 11 recessive bits in bus-off.
// - Reset mode request during bus-off leaves bus-off without recovery flag.
// - Forced exit bit leaves bus-off at once without recovery flag.
// - Policy 01 enters standby when bus-off starts, never setting recovery flag.
// - Policy 11 enters standby on software standby request during bus-off, no flag.
// - A message for an occupied receive buffer overwrites it, no interrupt.
// - A message for a full receive FIFO is dropped, loss flagged, global error.
// - A message for a full transmit/receive FIFO is dropped, loss flagged.
// - Each rule compares ID, IDE and RTR under its own masks.
// - With mirror on, each rule selects own-node or other-node messages.
// - With DLC check on, a short DLC against the rule flags an error.
// - With check and replacement on, the rule DLC is stored instead.
// - The matching rule's storage selection picks FIFOs or receive buffer.
// - The matching rule's label travels with every stored message.
// - An illegal acknowledge delimiter level sets the delimiter form flag.
// - Sending dominant but seeing recessive sets the recessive bit error flag.
// - Any protocol error sets the bus error summary and may request interrupt.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module crxef_top #(
    parameter int NRULES = 16
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic ERR_ADLM,
    input wire logic ERR_REC_BIT,
    input wire logic ERR_DOM_BIT,
    input wire logic ERR_CRC,
    input wire logic ERR_ACK,
    input wire logic ERR_FORM,
    input wire logic ERR_STUFF,
    input wire logic BUSOFF_START,
    input wire logic REC11_SEEN,
    input wire logic RX_VALID,
    input wire logic [28:0] RX_ID,
    input wire logic RX_IDE,
    input wire logic RX_RTR,
    input wire logic [3:0] RX_DLC,
    input wire logic RX_OWN,
    input wire logic [7:0] RXF_FULL,
    input wire logic TRF_FULL,
    output logic STORE_VALID,
    output logic [3:0] STORE_DLC,
    output logic [11:0] STORE_LABEL,
    output logic [7:0] STORE_RXF,
    output logic STORE_TRF,
    output logic STORE_BUF,
    output logic [5:0] STORE_BUF_NUM,
    output logic [1:0] CH_MODE,
    output logic CH_ERR_IRQ,
    output logic GLOBAL_ERR_IRQ
);
    localparam int RIDX_W = (NRULES > 1) ? $clog2(NRULES) : 1;

    logic [31:0] gcfg_reg;
    logic [31:0] ctrl_reg;
    logic [8:0] erfl_reg;
    logic [8:0] erfl_next;
    logic [15:0] gerfl_reg;
    logic [15:0] gerfl_next;
    logic [31:0] rule_id_reg [0:NRULES-1];
    logic [31:0] rule_mask_reg [0:NRULES-1];
    logic [31:0] rule_ptr_reg [0:NRULES-1];
    crxef_pkg::crxef_state_t st_reg;
    crxef_pkg::crxef_state_t st_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic busoff_recovery_flag_set;
    logic [31:0] rdata_next;

    // Register decode
    wire gcfg_wr = WR && (ADDR == crxef_pkg::OFS_GCFG);
    wire ctrl_wr = WR && (ADDR == crxef_pkg::OFS_CTRL);
    wire erfl_wr = WR && (ADDR == crxef_pkg::OFS_ERFL);
    wire gerfl_wr = WR && (ADDR == crxef_pkg::OFS_GERFL);
    wire rule_hit = (ADDR[11:8] == crxef_pkg::RULE_PAGE) && ({1'b0, ADDR[7:4]} < 5'(NRULES));
    wire rule_wr = WR && rule_hit;
    wire [3:0] rule_idx = ADDR[7:4];
    wire [1:0] req_mode = WDATA[crxef_pkg::CTL_MODE_LSB +: 2];
    wire fboe_wr = ctrl_wr && WDATA[crxef_pkg::CTL_FBOE];
    wire [1:0] pol = ctrl_reg[crxef_pkg::CTL_POL_LSB +: 2];
    wire dce = gcfg_reg[crxef_pkg::GCFG_DCE];
    wire dre = gcfg_reg[crxef_pkg::GCFG_DRE];
    wire mirror = gcfg_reg[crxef_pkg::GCFG_MIRR];
    wire [4:0] rule_num = gcfg_reg[crxef_pkg::GCFG_RNUM_LSB +: 5];

    // Protocol error events in flag-bit order
    wire [7:1] ev = {ERR_STUFF, ERR_FORM, ERR_ACK, ERR_CRC, ERR_DOM_BIT, ERR_REC_BIT, ERR_ADLM};
    wire ev_any = |ev;

    // Acceptance filter, one comparator per rule
    logic [NRULES-1:0] hit;
    genvar g;
    generate
        for (g = 0; g < NRULES; g++)
        begin : g_rule
            wire [30:0] rx_key = {RX_IDE, RX_RTR, RX_ID};
            wire [30:0] rl_key = {rule_id_reg[g][31:30], rule_id_reg[g][28:0]};
            wire [30:0] rl_msk = {rule_mask_reg[g][31:30], rule_mask_reg[g][28:0]};
            wire key_ok = ((rx_key ^ rl_key) & rl_msk) == 31'h0000_0000;
            // Without mirror, own transmissions never reach the filter
            wire src_ok = mirror ? (rule_id_reg[g][crxef_pkg::ID_OWN] == RX_OWN) : !RX_OWN;
            assign hit[g] = (5'(g) < rule_num) && key_ok && src_ok;
        end
    endgenerate

    // Lowest numbered matching rule wins
    logic [RIDX_W-1:0] sel;
    logic any_hit;
    always_comb
    begin
        sel = '0;
        any_hit = 1'b0;
        for (int i = NRULES - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                sel = RIDX_W'(i);
                any_hit = 1'b1;
            end
        end
    end

    wire [31:0] sel_ptr = rule_ptr_reg[sel];
    wire [3:0] rule_dlc = sel_ptr[crxef_pkg::PTR_DLC_LSB +: 4];
    wire dlc_ok = !dce || (RX_DLC >= rule_dlc);
    wire matched = RX_VALID && any_hit;
    wire accept = matched && dlc_ok;
    wire dlc_fail = matched && !dlc_ok;
    wire [7:0] rxf_route = accept ? sel_ptr[crxef_pkg::PTR_RXF_LSB +: 8] : 8'h00;
    wire [7:0] lost_rxf = rxf_route & RXF_FULL;
    wire [7:0] put_rxf = rxf_route & ~RXF_FULL;
    wire trf_route = accept && sel_ptr[crxef_pkg::PTR_TRF];
    wire lost_trf = trf_route && TRF_FULL;
    wire put_trf = trf_route && !TRF_FULL;
    // Receive buffer has no full state: an unread entry is simply overwritten
    wire put_buf = accept && sel_ptr[crxef_pkg::PTR_BUF];
    wire store_any = (put_rxf != 8'h00) || put_trf || put_buf;
    wire [3:0] dlc_out = (dce && dre) ? rule_dlc : RX_DLC;

    // Bus-off recovery and channel mode
    always_comb
    begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        busoff_recovery_flag_set = 1'b0;
        case (st_reg)
            crxef_pkg::ST_RESET, crxef_pkg::ST_STBY, crxef_pkg::ST_COMM:
            begin
                if (ctrl_wr && req_mode == crxef_pkg::MODE_COMM)
                    st_next = crxef_pkg::ST_COMM;
                else if (ctrl_wr && req_mode == crxef_pkg::MODE_RESET)
                    st_next = crxef_pkg::ST_RESET;
                else if (ctrl_wr && req_mode == crxef_pkg::MODE_STBY)
                    st_next = crxef_pkg::ST_STBY;
                else if (st_reg == crxef_pkg::ST_COMM && BUSOFF_START)
                begin
                    cnt_next = 8'h00;
                    if (pol == crxef_pkg::POL_STBY_START)
                        st_next = crxef_pkg::ST_STBY;
                    else
                        st_next = crxef_pkg::ST_BUSOFF;
                end
            end
            crxef_pkg::ST_BUSOFF:
            begin
                // A software exit in the same cycle as the last sequence wins, with no flag
                if (fboe_wr)
                    st_next = crxef_pkg::ST_COMM;
                else if (ctrl_wr && req_mode == crxef_pkg::MODE_RESET)
                    st_next = crxef_pkg::ST_RESET;
                else if (ctrl_wr && req_mode == crxef_pkg::MODE_STBY && pol == crxef_pkg::POL_STBY_REQ)
                    st_next = crxef_pkg::ST_STBY;
                else if (REC11_SEEN)
                begin
                    if (cnt_reg == crxef_pkg::BO_SEQ_CNT - 8'h01)
                    begin
                        st_next = crxef_pkg::ST_COMM;
                        busoff_recovery_flag_set = 1'b1;
                    end
                    else
                        cnt_next = cnt_reg + 8'h01;
                end
            end
            default:
                st_next = crxef_pkg::ST_RESET;
        endcase
    end

    // Flags: a write of zero clears, a set in the same cycle wins
    wire [8:0] erfl_keep = erfl_wr ? WDATA[8:0] : 9'h1FF;
    wire [8:0] erfl_set = {busoff_recovery_flag_set, ev, ev_any};
    assign erfl_next = (erfl_reg & erfl_keep) | erfl_set;
    wire [15:0] gerfl_keep = gerfl_wr ? WDATA[15:0] : 16'hFFFF;
    wire [15:0] gerfl_set = {lost_rxf, 6'h00, lost_trf, dlc_fail};
    assign gerfl_next = (gerfl_reg & gerfl_keep) | gerfl_set;
    wire lost_any = (gerfl_reg[crxef_pkg::GE_RXF_LSB +: 8] != 8'h00) || gerfl_reg[crxef_pkg::GE_TRF_LOST];
    wire gerr_next = gerfl_reg[crxef_pkg::GE_DLC] || (gcfg_reg[crxef_pkg::GCFG_MLIE] && lost_any);
    wire cherr_next = (ctrl_reg[crxef_pkg::CTL_BEIE] && erfl_reg[crxef_pkg::EF_BUS])
        || (ctrl_reg[crxef_pkg::CTL_BORIE] && erfl_reg[crxef_pkg::EF_BUSOFF_RECOVERY_FLAG]);

    // Read mux
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (ADDR == crxef_pkg::OFS_GCFG)
            rdata_next = gcfg_reg;
        else if (ADDR == crxef_pkg::OFS_CTRL)
            rdata_next = ctrl_reg;
        else if (ADDR == crxef_pkg::OFS_ERFL)
            rdata_next = {23'h00_0000, erfl_reg};
        else if (ADDR == crxef_pkg::OFS_STS)
            rdata_next = {16'h0000, cnt_reg, 6'h00, st_reg};
        else if (ADDR == crxef_pkg::OFS_GERFL)
            rdata_next = {16'h0000, gerfl_reg};
        else if (rule_hit && ADDR[3:2] == crxef_pkg::SUB_ID)
            rdata_next = rule_id_reg[rule_idx];
        else if (rule_hit && ADDR[3:2] == crxef_pkg::SUB_MASK)
            rdata_next = rule_mask_reg[rule_idx];
        else if (rule_hit && ADDR[3:2] == crxef_pkg::SUB_PTR)
            rdata_next = rule_ptr_reg[rule_idx];
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            gcfg_reg <= crxef_pkg::GCFG_RST;
            ctrl_reg <= crxef_pkg::CTL_RST;
        end
        else
        begin
            if (gcfg_wr)
                gcfg_reg <= WDATA;
            // The forced exit bit is a strobe and never stored
            if (ctrl_wr)
                ctrl_reg <= WDATA & ~(32'h0000_0001 << crxef_pkg::CTL_FBOE);
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            for (int i = 0; i < NRULES; i++)
            begin
                rule_id_reg[i] <= 32'h0000_0000;
                rule_mask_reg[i] <= 32'h0000_0000;
                rule_ptr_reg[i] <= 32'h0000_0000;
            end
        end
        else if (rule_wr)
        begin
            if (ADDR[3:2] == crxef_pkg::SUB_ID)
                rule_id_reg[rule_idx] <= WDATA;
            if (ADDR[3:2] == crxef_pkg::SUB_MASK)
                rule_mask_reg[rule_idx] <= WDATA;
            if (ADDR[3:2] == crxef_pkg::SUB_PTR)
                rule_ptr_reg[rule_idx] <= WDATA;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            st_reg <= crxef_pkg::ST_RESET;
            cnt_reg <= 8'h00;
            erfl_reg <= 9'h000;
            gerfl_reg <= 16'h0000;
            CH_MODE <= crxef_pkg::MODE_RESET;
            CH_ERR_IRQ <= 1'b0;
            GLOBAL_ERR_IRQ <= 1'b0;
            RDATA <= 32'h0000_0000;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            erfl_reg <= erfl_next;
            gerfl_reg <= gerfl_next;
            CH_MODE <= (st_next == crxef_pkg::ST_STBY) ? crxef_pkg::MODE_STBY
                : (st_next == crxef_pkg::ST_RESET) ? crxef_pkg::MODE_RESET : crxef_pkg::MODE_COMM;
            CH_ERR_IRQ <= cherr_next;
            GLOBAL_ERR_IRQ <= gerr_next;
            RDATA <= RD ? rdata_next : 32'h0000_0000;
        end
    end

    // Store request to the message RAM, one cycle after the frame is offered
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            STORE_VALID <= 1'b0;
            STORE_DLC <= 4'h0;
            STORE_LABEL <= 12'h000;
            STORE_RXF <= 8'h00;
            STORE_TRF <= 1'b0;
            STORE_BUF <= 1'b0;
            STORE_BUF_NUM <= 6'h00;
        end
        else
        begin
            STORE_VALID <= store_any;
            STORE_DLC <= dlc_out;
            STORE_LABEL <= sel_ptr[crxef_pkg::PTR_LBL_LSB +: 12];
            STORE_RXF <= put_rxf;
            STORE_TRF <= put_trf;
            STORE_BUF <= put_buf;
            STORE_BUF_NUM <= sel_ptr[crxef_pkg::PTR_BNUM_LSB +: 6];
        end
    end

    property p_dom_err;
        @(posedge CLK_SYS) disable iff (!RESETN)
        ERR_DOM_BIT |=> erfl_reg[crxef_pkg::EF_DOM] && erfl_reg[crxef_pkg::EF_BUS];
    endproperty
    a_dom_err: assert property (p_dom_err) else $error("dominant bit error not flagged");

    property p_stuff_err;
        @(posedge CLK_SYS) disable iff (!RESETN)
        ERR_STUFF |=> erfl_reg[crxef_pkg::EF_STUFF];
    endproperty
    a_stuff_err: assert property (p_stuff_err) else $error("stuff error not flagged");

    property p_summary;
        @(posedge CLK_SYS) disable iff (!RESETN)
        ev_any ##1 ctrl_reg[crxef_pkg::CTL_BEIE] |=> CH_ERR_IRQ;
    endproperty
    a_summary: assert property (p_summary) else $error("bus error summary not raised");

    property p_hold;
        @(posedge CLK_SYS) disable iff (!RESETN)
        erfl_reg[crxef_pkg::EF_CRC] && !erfl_wr |=> erfl_reg[crxef_pkg::EF_CRC];
    endproperty
    a_hold: assert property (p_hold) else $error("crc flag dropped without write");

    property p_busoff_recovery_flag;
        @(posedge CLK_SYS) disable iff (!RESETN)
        $rose(erfl_reg[crxef_pkg::EF_BUSOFF_RECOVERY_FLAG]) |-> $past(st_reg) == crxef_pkg::ST_BUSOFF
            && $past(cnt_reg) == crxef_pkg::BO_SEQ_CNT - 8'h01 && $past(REC11_SEEN)
            && st_reg == crxef_pkg::ST_COMM;
    endproperty
    a_busoff_recovery_flag: assert property (p_busoff_recovery_flag) else $error("recovery flag without 128 sequences");

    property p_fboe;
        @(posedge CLK_SYS) disable iff (!RESETN)
        st_reg == crxef_pkg::ST_BUSOFF && fboe_wr |=> st_reg == crxef_pkg::ST_COMM
            && !$rose(erfl_reg[crxef_pkg::EF_BUSOFF_RECOVERY_FLAG]);
    endproperty
    a_fboe: assert property (p_fboe) else $error("forced exit misbehaved");

    property p_pol_start;
        @(posedge CLK_SYS) disable iff (!RESETN)
        st_reg == crxef_pkg::ST_COMM && BUSOFF_START && !ctrl_wr && pol == crxef_pkg::POL_STBY_START
            |=> st_reg == crxef_pkg::ST_STBY && CH_MODE == crxef_pkg::MODE_STBY;
    endproperty
    a_pol_start: assert property (p_pol_start) else $error("standby on bus-off start missed");

    property p_lost;
        @(posedge CLK_SYS) disable iff (!RESETN)
        lost_rxf != 8'h00 |=> (STORE_RXF & $past(lost_rxf)) == 8'h00
            && (gerfl_reg[crxef_pkg::GE_RXF_LSB +: 8] & $past(lost_rxf)) == $past(lost_rxf);
    endproperty
    a_lost: assert property (p_lost) else $error("full FIFO message not discarded");

    property p_nomatch;
        @(posedge CLK_SYS) disable iff (!RESETN)
        RX_VALID && !any_hit && !gerfl_wr |=> !STORE_VALID && $stable(gerfl_reg[crxef_pkg::GE_DLC]);
    endproperty
    a_nomatch: assert property (p_nomatch) else $error("unmatched message stored");
endmodule

/* dv/crxef_bus_model.sv */
// Behavioural model of the bus side: protocol engine events and received frames
`timescale 1ns/1ps
module crxef_bus_model (
    input wire logic clk,
    output logic [6:0] err_pulse,
    output logic busoff_start,
    output logic rec11_seen,
    output logic rx_valid,
    output logic [28:0] rx_id,
    output logic rx_ide,
    output logic rx_rtr,
    output logic [3:0] rx_dlc,
    output logic rx_own
);
    initial
    begin
        err_pulse = '0;
        busoff_start = 1'b0;
        rec11_seen = 1'b0;
        rx_valid = 1'b0;
        rx_id = '0;
        rx_ide = 1'b0;
        rx_rtr = 1'b0;
        rx_dlc = '0;
        rx_own = 1'b0;
    end

    // Event k: 0..6 protocol errors, 7 bus-off start, 8 one run of 11 recessive bits
    task automatic pulse(input int k);
        @(posedge clk);
        if (k < 7)
            err_pulse[k] <= 1'b1;
        else if (k == 7)
            busoff_start <= 1'b1;
        else
            rec11_seen <= 1'b1;
        @(posedge clk);
        err_pulse <= '0;
        busoff_start <= 1'b0;
        rec11_seen <= 1'b0;
    endtask

    task automatic rec(input int n);
        repeat (n) pulse(8);
    endtask

    // Fields turn to garbage after the strobe so late sampling is caught
    task automatic frame(input logic [28:0] id, input logic ide, input logic rtr, input logic own,
                         input logic [3:0] dlc);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_id <= id;
        rx_ide <= ide;
        rx_rtr <= rtr;
        rx_own <= own;
        rx_dlc <= dlc;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_id <= ~id;
        rx_ide <= ~ide;
        rx_rtr <= ~rtr;
        rx_own <= ~own;
        rx_dlc <= ~dlc;
    endtask
endmodule

/* dv/crxef_top_tb.sv */
// Self-checking testbench for the receive error and filter block
`timescale 1ns/1ps
module crxef_top_tb;
    logic clk_sys, resetn, wr_s, rd_s, bo_start, rec11, rx_valid, rx_ide, rx_rtr, rx_own, trf_full;
    logic [11:0] addr;
    logic [31:0] wdata, rdata;
    logic [6:0] err;
    logic [28:0] rx_id;
    logic [3:0] rx_dlc, store_dlc;
    logic [7:0] rxf_full, store_rxf;
    logic store_valid, store_trf, store_buf, ch_err_irq, global_err_irq;
    logic [11:0] store_label;
    logic [5:0] store_buf_num;
    logic [1:0] ch_mode;
    int err_count;
    int checks_done;
    logic [31:0] rules [9] = '{32'h0000_0123, 32'hDFFF_FFFF, 32'h0001_ABC4, 32'h2000_0123, 32'hDFFF_FFFF,
                               32'h1600_1110, 32'h0000_0200, 32'hDFFF_FF00, 32'h0100_2228};
    logic [31:0] bo_pre [5] = '{32'h0000_0060, 32'h0000_0060, 32'h0000_0060, 32'h0000_0068, 32'h0000_0078};
    logic [31:0] bo_exit [5] = '{32'h0000_0000, 32'h0000_0064, 32'h0000_0061, 32'h0000_0000, 32'h0000_007A};
    int bo_n [5] = '{128, 127, 10, 128, 50};
    logic [1:0] bo_st [5] = '{crxef_pkg::ST_COMM, crxef_pkg::ST_COMM, crxef_pkg::ST_RESET, crxef_pkg::ST_STBY,
                              crxef_pkg::ST_STBY};
    logic [1:0] bo_md [5] = '{crxef_pkg::MODE_COMM, crxef_pkg::MODE_COMM, crxef_pkg::MODE_RESET,
                              crxef_pkg::MODE_STBY, crxef_pkg::MODE_STBY};
    logic [31:0] bo_ef [5] = '{32'h0000_0100, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

    crxef_top dut (.CLK_SYS(clk_sys), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
        .RDATA(rdata), .ERR_ADLM(err[0]), .ERR_REC_BIT(err[1]), .ERR_DOM_BIT(err[2]), .ERR_CRC(err[3]),
        .ERR_ACK(err[4]), .ERR_FORM(err[5]), .ERR_STUFF(err[6]), .BUSOFF_START(bo_start), .REC11_SEEN(rec11),
        .RX_VALID(rx_valid), .RX_ID(rx_id), .RX_IDE(rx_ide), .RX_RTR(rx_rtr), .RX_DLC(rx_dlc), .RX_OWN(rx_own),
        .RXF_FULL(rxf_full), .TRF_FULL(trf_full), .STORE_VALID(store_valid), .STORE_DLC(store_dlc),
        .STORE_LABEL(store_label), .STORE_RXF(store_rxf), .STORE_TRF(store_trf), .STORE_BUF(store_buf),
        .STORE_BUF_NUM(store_buf_num), .CH_MODE(ch_mode), .CH_ERR_IRQ(ch_err_irq),
        .GLOBAL_ERR_IRQ(global_err_irq));

    crxef_bus_model bus (.clk(clk_sys), .err_pulse(err), .busoff_start(bo_start), .rec11_seen(rec11),
        .rx_valid(rx_valid), .rx_id(rx_id), .rx_ide(rx_ide), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_own(rx_own));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_sys);
        wr_s <= 1'b0;
    endtask

    // Read data is looked at only in the single cycle after the strobe
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
        @(posedge clk_sys);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_sys);
        rd_s <= 1'b0;
        #1;
        chk(what, exp, rdata & m);
    endtask

    // Expected fields packed as dlc, label, buffer number, buffer, tr FIFO, rx FIFOs
    task automatic rxc(input logic [28:0] id, input logic [2:0] f, input logic [3:0] dlc, input logic ev,
                       input logic [31:0] e);
        bus.frame(id, f[2], f[1], f[0], dlc);
        #1;
        chk("store valid", {31'h0, ev}, {31'h0, store_valid});
        if (ev)
            chk("store fields", e, {store_dlc, store_label, store_buf_num, store_buf, store_trf, store_rxf});
    endtask

    initial
    begin
        logic [31:0] acc;
        resetn = 1'b0;
        addr = '0;
        wdata = '0;
        wr_s = 1'b0;
        rd_s = 1'b0;
        rxf_full = '0;
        trf_full = 1'b0;
        err_count = 0;
        checks_done = 0;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        rdc(crxef_pkg::OFS_CTRL, 32'hFFFF_FFFF, crxef_pkg::CTL_RST, "control reset");
        rdc(crxef_pkg::OFS_ERFL, 32'h0000_01FF, 32'h0000_0000, "flags reset");
        chk("mode reset", {30'h0, crxef_pkg::MODE_RESET}, {30'h0, ch_mode});
        wr(12'h7FC, 32'hFFFF_FFFF);
        rdc(12'h7FC, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
        wr(crxef_pkg::OFS_CTRL, 32'h0000_0060);
        acc = 32'h0000_0001;
        for (int k = 0; k < 7; k++)
        begin
            bus.pulse(k);
            acc = acc | (32'h0000_0002 << k);
            rdc(crxef_pkg::OFS_ERFL, 32'h0000_01FF, acc, "error flags");
            chk("channel irq", 32'h0000_0001, {31'h0, ch_err_irq});
        end
        wr(crxef_pkg::OFS_ERFL, 32'h0000_0000);
        rdc(crxef_pkg::OFS_ERFL, 32'h0000_01FF, 32'h0000_0000, "flags cleared");
        $display("error flag test done");
        for (int c = 0; c < 5; c++)
        begin
            wr(crxef_pkg::OFS_CTRL, bo_pre[c]);
            bus.pulse(7);
            bus.rec(bo_n[c]);
            if (bo_exit[c] != 32'h0000_0000)
            begin
                rdc(crxef_pkg::OFS_STS, 32'h0000_FF03, {16'h0, 8'(bo_n[c]), 8'h03}, "bus-off count");
                wr(crxef_pkg::OFS_CTRL, bo_exit[c]);
            end
            rdc(crxef_pkg::OFS_STS, 32'h0000_0003, {30'h0, bo_st[c]}, "state");
            rdc(crxef_pkg::OFS_ERFL, 32'h0000_01FF, bo_ef[c], "recovery flag");
            chk("channel mode", {30'h0, bo_md[c]}, {30'h0, ch_mode});
            chk("recovery irq", {31'h0, bo_ef[c][8]}, {31'h0, ch_err_irq});
            wr(crxef_pkg::OFS_ERFL, 32'h0000_0000);
            wr(crxef_pkg::OFS_CTRL, 32'h0000_0060);
            $display("bus-off case %0d done", c);
        end
        for (int j = 0; j < 9; j++)
            wr(12'h100 + 12'(16 * (j / 3) + 4 * (j % 3)), rules[j]);
        wr(crxef_pkg::OFS_GCFG, 32'h0000_0308);
        rxc(29'h123, 3'b000, 4'h6, 1'b1, 32'h6ABC_0001);
        rxc(29'h123, 3'b100, 4'h6, 1'b0, 32'h0);
        rxc(29'h123, 3'b010, 4'h6, 1'b0, 32'h0);
        rxc(29'h124, 3'b000, 4'h6, 1'b0, 32'h0);
        rxc(29'h123, 3'b001, 4'h6, 1'b0, 32'h0);
        rxc(29'h2A5, 3'b000, 4'h9, 1'b1, 32'h9222_0100);
        wr(crxef_pkg::OFS_GCFG, 32'h0000_030C);
        rxc(29'h123, 3'b001, 4'h7, 1'b1, 32'h7111_1600);
        rxc(29'h123, 3'b001, 4'h3, 1'b1, 32'h3111_1600);
        rdc(crxef_pkg::OFS_GERFL, 32'h0000_FF03, 32'h0000_0000, "no loss");
        chk("global irq", 32'h0, {31'h0, global_err_irq});
        wr(crxef_pkg::OFS_GCFG, 32'h0000_0309);
        rxc(29'h2A5, 3'b000, 4'h7, 1'b0, 32'h0);
        rdc(crxef_pkg::OFS_GERFL, 32'h0000_FF03, 32'h0000_0001, "dlc error");
        chk("global irq", 32'h1, {31'h0, global_err_irq});
        wr(crxef_pkg::OFS_GERFL, 32'h0000_0000);
        wr(crxef_pkg::OFS_GCFG, 32'h0000_030B);
        rxc(29'h2A5, 3'b000, 4'hC, 1'b1, 32'h8222_0100);
        @(posedge clk_sys);
        rxf_full <= 8'h01;
        rxc(29'h123, 3'b000, 4'h6, 1'b0, 32'h0);
        rdc(crxef_pkg::OFS_GERFL, 32'h0000_FF03, 32'h0000_0100, "fifo lost");
        chk("global irq", 32'h1, {31'h0, global_err_irq});
        wr(crxef_pkg::OFS_GERFL, 32'h0000_0000);
        rxf_full <= 8'h00;
        trf_full <= 1'b1;
        rxc(29'h2A5, 3'b000, 4'hC, 1'b0, 32'h0);
        rdc(crxef_pkg::OFS_GERFL, 32'h0000_FF03, 32'h0000_0002, "tr fifo lost");
        chk("global irq", 32'h1, {31'h0, global_err_irq});
        wr(crxef_pkg::OFS_GERFL, 32'h0000_0000);
        trf_full <= 1'b0;
        wr(crxef_pkg::OFS_GCFG, 32'h0000_0200);
        rxc(29'h2A5, 3'b000, 4'hC, 1'b0, 32'h0);
        $display("filter test done");
        stop_test();
    end

    // Whole run needs about a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        stop_test();
    end
endmodule
